// >>> hmf_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module hmf_asserts #(
    parameter int PADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic rx_skip_to_next_frame,
    input wire logic rx_skip_done,
    input wire logic mac_csr_req,
    input wire logic mac_csr_rnw,
    input wire logic [7:0] mac_csr_addr,
    input wire logic mac_csr_ack
);
    // ------------------------------------------------------------
    // Bus and link checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc_wr = psel && penable && pready && pwrite && pstrb[3];
    wire logic skip_hit = paddr == PADDR_W'(hmf_pkg::OFF_SKIP_CTRL);
    wire logic cmd_hit = paddr == PADDR_W'(hmf_pkg::OFF_IND_CMD);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_req_held;
        mac_csr_req && $stable(mac_csr_addr) && $stable(mac_csr_rnw);
    endsequence
    AST_PREADY_SETUP: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (psel && !penable && paddr == PADDR_W'(8'h90)
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not flagged");
    AST_SKIP_START: assert property (acc_wr && skip_hit && pwdata[31]
        && !rx_skip_to_next_frame |=> rx_skip_to_next_frame) else $error("skip not started");
    AST_SKIP_HOLD: assert property (rx_skip_to_next_frame && !rx_skip_done
        |=> rx_skip_to_next_frame) else $error("skip dropped early");
    AST_SKIP_END: assert property (rx_skip_to_next_frame && rx_skip_done
        |=> !rx_skip_to_next_frame) else $error("skip not ended");
    AST_REQ_START: assert property (acc_wr && cmd_hit && pstrb[0]
        && pwdata[31] && !mac_csr_req
        |=> mac_csr_req && mac_csr_rnw == $past(pwdata[30]) && mac_csr_addr == $past(pwdata[7:0]))
        else $error("indirect request wrong");
    AST_REQ_HOLD: assert property (mac_csr_req && !mac_csr_ack |=> s_req_held)
        else $error("indirect request not held");
    AST_REQ_END: assert property (mac_csr_req && mac_csr_ack |=> !mac_csr_req)
        else $error("indirect request not ended");
endmodule
bind hmf_csr hmf_asserts #(.PADDR_W(PADDR_W)) i_asserts (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .rx_skip_to_next_frame,
    .rx_skip_done, .mac_csr_req, .mac_csr_rnw, .mac_csr_addr, .mac_csr_ack);
`default_nettype wire

// >>> hmf_csr.sv
`timescale 1ns/1ps
`default_nettype none
module hmf_csr #(
    parameter int PADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    output logic rx_skip_to_next_frame,
    input wire logic rx_skip_done,
    input wire logic [7:0] rx_status_words_used,
    input wire logic [15:0] rx_data_bytes_used,
    input wire logic [7:0] tx_status_words_used,
    input wire logic [15:0] tx_data_bytes_free,
    input wire logic frame_discarded,
    output logic mac_csr_req,
    output logic mac_csr_rnw,
    output logic [7:0] mac_csr_addr,
    output logic [31:0] mac_csr_wdata,
    input wire logic mac_csr_ack,
    input wire logic [31:0] mac_csr_rdata
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (PADDR_W < 8) begin : g_bad_addr
        $error("PADDR_W must be at least 8");
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [7:0] off);
        logic [PADDR_W-1:0] full;
        full = PADDR_W'(off);
        // Word compare: byte lane bits of the address never select a register
        hit = (a[PADDR_W-1:2] == full[PADDR_W-1:2]);
    endfunction

    logic setup_w;
    logic access_w;
    logic wr_w;
    logic rd_w;
    assign setup_w = psel && !penable && !pready;
    assign access_w = psel && penable && pready;
    assign wr_w = access_w && pwrite;
    assign rd_w = access_w && !pwrite;

    logic sel_skip;
    logic sel_rxocc;
    logic sel_txinf;
    logic sel_drop;
    logic sel_cmd;
    logic sel_data;
    logic sel_ists;
    logic sel_iclr;
    logic sel_ien;
    logic mapped_w;
    assign sel_skip = hit(paddr, hmf_pkg::OFF_SKIP_CTRL);
    assign sel_rxocc = hit(paddr, hmf_pkg::OFF_RX_OCC);
    assign sel_txinf = hit(paddr, hmf_pkg::OFF_TX_INFO);
    assign sel_drop = hit(paddr, hmf_pkg::OFF_DROP_CNT);
    assign sel_cmd = hit(paddr, hmf_pkg::OFF_IND_CMD);
    assign sel_data = hit(paddr, hmf_pkg::OFF_IND_DATA);
    assign sel_ists = hit(paddr, hmf_pkg::OFF_INTERRUPT_STATUS_REG);
    assign sel_iclr = hit(paddr, hmf_pkg::OFF_INT_CLR);
    assign sel_ien = hit(paddr, hmf_pkg::OFF_INT_EN);
    assign mapped_w = sel_skip | sel_rxocc | sel_txinf | sel_drop | sel_cmd
                    | sel_data | sel_ists | sel_iclr | sel_ien;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic skip_busy_r;
    logic [7:0] rx_sused_r;
    logic [15:0] rx_dused_r;
    logic [7:0] tx_sused_r;
    logic [15:0] tx_free_r;
    logic [31:0] drop_cnt_r;
    logic [31:0] drop_snap_r;
    hmf_pkg::hmf_state_t state_r;
    logic rnw_r;
    logic [7:0] csr_addr_r;
    logic [31:0] data_r;
    logic [31:0] interrupt_status_reg_r;
    logic [31:0] int_en_r;
    logic irq_r;

    logic busy_w;
    assign busy_w = (state_r == hmf_pkg::HMF_WAIT);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    logic [31:0] skip_rd;
    logic [31:0] rxocc_rd;
    logic [31:0] txinf_rd;
    logic [31:0] cmd_rd;
    logic [31:0] rd_mux;
    assign skip_rd = {skip_busy_r, 31'h0000_0000};
    assign rxocc_rd = {8'h00, rx_sused_r, rx_dused_r};
    assign txinf_rd = {8'h00, tx_sused_r, tx_free_r};
    assign cmd_rd = {busy_w, rnw_r, 22'h00_0000, csr_addr_r};
    assign rd_mux = sel_skip ? skip_rd :
                    sel_rxocc ? rxocc_rd :
                    sel_txinf ? txinf_rd :
                    sel_drop ? drop_cnt_r :
                    sel_cmd ? cmd_rd :
                    sel_data ? data_r :
                    sel_ists ? interrupt_status_reg_r :
                    sel_ien ? int_en_r : 32'h0000_0000;

    // ------------------------------------------------------------
    // APB answer: one wait-free access cycle after setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup_w;
            prdata_r <= (setup_w && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_r <= setup_w && !mapped_w;
        end
    end

    // ------------------------------------------------------------
    // FIFO level readouts
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sused_r <= 8'h00;
            rx_dused_r <= 16'h0000;
            tx_sused_r <= 8'h00;
            tx_free_r <= hmf_pkg::TX_FREE_RST; // [R7]
        end else begin
            rx_sused_r <= rx_status_words_used; // [R4]
            rx_dused_r <= rx_data_bytes_used; // [R5]
            tx_sused_r <= tx_status_words_used; // [R6]
            tx_free_r <= tx_data_bytes_free; // [R7]
        end
    end

    // ------------------------------------------------------------
    // Receive skip to next frame
    // ------------------------------------------------------------
    logic skip_start_w;
    assign skip_start_w = wr_w && sel_skip && pwdata[hmf_pkg::SKIP_BIT] && pstrb[3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_busy_r <= 1'b0;
        end else if (skip_busy_r) begin
            // Writes of zero cannot abort a running skip
            skip_busy_r <= !rx_skip_done; // [R2] [R19]
        end else begin
            skip_busy_r <= skip_start_w; // [R1]
        end
    end

    // ------------------------------------------------------------
    // Discarded frame counter
    // ------------------------------------------------------------
    logic drop_rc_w;
    logic [31:0] drop_base_w;
    logic [31:0] drop_nxt;
    logic half_w;
    assign drop_rc_w = rd_w && sel_drop;
    // Subtract the snapshot so a discard between setup and access survives the clear
    assign drop_base_w = drop_rc_w ? drop_cnt_r - drop_snap_r : drop_cnt_r; // [R10]
    assign drop_nxt = drop_base_w + {31'h0000_0000, frame_discarded}; // [R9]
    assign half_w = frame_discarded && (drop_base_w == hmf_pkg::DROP_HALF_FROM); // [R11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_cnt_r <= 32'h0000_0000;
            drop_snap_r <= 32'h0000_0000;
        end else begin
            drop_cnt_r <= drop_nxt;
            if (setup_w && !pwrite && sel_drop) begin
                drop_snap_r <= drop_cnt_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Indirect MAC CSR access
    // ------------------------------------------------------------
    logic cmd_wr_w;
    logic ind_start_w;
    logic ind_done_w;
    assign cmd_wr_w = wr_w && sel_cmd && !busy_w;
    assign ind_start_w = cmd_wr_w && pwdata[hmf_pkg::BUSY_BIT] && pstrb[3]; // [R12]
    assign ind_done_w = busy_w && mac_csr_ack;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= hmf_pkg::HMF_IDLE;
        end else begin
            unique case (state_r)
                hmf_pkg::HMF_IDLE: begin
                    if (ind_start_w) begin
                        state_r <= hmf_pkg::HMF_WAIT; // [R12]
                    end
                end
                hmf_pkg::HMF_WAIT: begin
                    // Only the MAC acknowledge ends busy; host writes are ignored
                    if (mac_csr_ack) begin
                        state_r <= hmf_pkg::HMF_IDLE; // [R13] [R19]
                    end
                end
                default: begin
                    state_r <= hmf_pkg::HMF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rnw_r <= 1'b0;
            csr_addr_r <= 8'h00;
        end else if (cmd_wr_w) begin
            if (pstrb[3]) begin
                rnw_r <= pwdata[hmf_pkg::RNW_BIT]; // [R16]
            end
            if (pstrb[0]) begin
                csr_addr_r <= pwdata[hmf_pkg::ADDR_LSB +: hmf_pkg::ADDR_W]; // [R17]
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_data_lane
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    data_r[gi*8 +: 8] <= 8'h00;
                end else if (ind_done_w && rnw_r) begin
                    data_r[gi*8 +: 8] <= mac_csr_rdata[gi*8 +: 8]; // [R14] [R18]
                end else if (wr_w && sel_data && !busy_w && pstrb[gi]) begin
                    data_r[gi*8 +: 8] <= pwdata[gi*8 +: 8]; // [R18]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // MAC side request, held until acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_csr_req <= 1'b0;
            mac_csr_rnw <= 1'b0;
            mac_csr_addr <= 8'h00;
            mac_csr_wdata <= 32'h0000_0000;
        end else if (ind_start_w) begin
            mac_csr_req <= 1'b1; // [R12]
            mac_csr_rnw <= pwdata[hmf_pkg::RNW_BIT]; // [R16]
            mac_csr_addr <= pstrb[0] ? pwdata[7:0] : csr_addr_r; // [R17]
            mac_csr_wdata <= data_r;
        end else if (mac_csr_ack) begin
            mac_csr_req <= 1'b0; // [R13]
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [31:0] int_set_w;
    logic [31:0] int_clr_w;
    logic [31:0] interrupt_status_reg_nxt;
    logic skip_end_w;
    assign skip_end_w = skip_busy_r && rx_skip_done;
    assign int_set_w = ({31'h0000_0000, skip_end_w} << hmf_pkg::INT_SKIP_DONE)
                     | ({31'h0000_0000, ind_done_w} << hmf_pkg::INT_IND_DONE)
                     | ({31'h0000_0000, half_w} << hmf_pkg::INT_HALFWAY); // [R11]
    assign int_clr_w = (wr_w && sel_iclr) ? pwdata : 32'h0000_0000;
    // Set wins over a clear in the same cycle
    assign interrupt_status_reg_nxt = ((interrupt_status_reg_r & ~int_clr_w) | int_set_w) & hmf_pkg::INT_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_status_reg_r <= 32'h0000_0000;
            int_en_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end else begin
            interrupt_status_reg_r <= interrupt_status_reg_nxt;
            if (wr_w && sel_ien) begin
                int_en_r <= pwdata & hmf_pkg::INT_MASK;
            end
            irq_r <= |(interrupt_status_reg_nxt & int_en_r);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign rx_skip_to_next_frame = skip_busy_r; // [R1]
endmodule
`default_nettype wire

// >>> hmf_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmf_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic skip_req,
    output logic skip_done,
    input wire logic csr_req,
    input wire logic csr_rnw,
    input wire logic [7:0] csr_addr,
    input wire logic [31:0] csr_wdata,
    output logic csr_ack,
    output logic [31:0] csr_rdata
);
    // ------------------------------------------------------------
    // FIFO skip and MAC CSR responder
    // ------------------------------------------------------------
    // Answer delay alternates slow and prompt so both paths are seen
    logic [31:0] mem [256];
    logic [3:0] dly, cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= {24'ha5a5a5, i[7:0]};
            end
            dly <= 4'h9;
            cnt <= 4'h0;
            skip_done <= 1'b0;
            csr_ack <= 1'b0;
            csr_rdata <= 32'h0;
        end else begin
            skip_done <= 1'b0;
            csr_ack <= 1'b0;
            csr_rdata <= ~csr_rdata;
            cnt <= (skip_req && !skip_done) || (csr_req && !csr_ack) ? cnt + 4'h1 : 4'h0;
            if (cnt == dly) begin
                dly <= 4'ha - dly;
                cnt <= 4'h0;
                skip_done <= skip_req;
                csr_ack <= csr_req;
                csr_rdata <= mem[csr_addr];
                if (csr_req && !csr_rnw) begin
                    mem[csr_addr] <= csr_wdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> hmf_pkg.sv
// Function
// [R1] Writing one to the skip bit moves the RX data read point to the next frame.
// [R2] Skip bit reads one while the skip runs and clears itself when it ends.
// [R3] Host should not read the RX data FIFO while the skip bit reads one.
// [R4] An 8-bit field shows the RX status FIFO words in use.
// [R5] A 16-bit field shows RX data FIFO bytes in use, rounded up to words.
// [R6] An 8-bit field shows the TX status FIFO words in use.
// [R7] A 16-bit field shows TX data FIFO free bytes, 1200h after reset.
// [R8] Host never pushes more TX bytes than the free field shows.
// [R9] A 32-bit counter adds one for every discarded received frame.
// [R10] Reading the discard counter returns the count, then clears it.
// [R11] Counter passing 7fffffff to 80000000 raises the discard halfway status bit.
// [R12] Writing one to the busy bit starts the indirect access to the addressed CSR.
// [R13] Busy stays set through the indirect access and clears itself when done.
// [R14] For an indirect read, busy clearing means the data register holds valid data.
// [R15] Host writes neither command nor data register while busy reads one.
// [R16] Command bit 30 selects direction: one reads, zero writes.
// [R17] The low command byte addresses the target MAC CSR.
// [R18] Data register returns fetched data after a read, last written value otherwise.
// [R19] Writing zero to the skip or busy bit leaves a running operation alone.
package hmf_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SKIP_CTRL = 8'h78;
    localparam logic [7:0] OFF_RX_OCC = 8'h7c;
    localparam logic [7:0] OFF_TX_INFO = 8'h80;
    localparam logic [7:0] OFF_DROP_CNT = 8'ha0;
    localparam logic [7:0] OFF_IND_CMD = 8'ha4;
    localparam logic [7:0] OFF_IND_DATA = 8'ha8;
    localparam logic [7:0] OFF_INTERRUPT_STATUS_REG = 8'hb0;
    localparam logic [7:0] OFF_INT_CLR = 8'hb4;
    localparam logic [7:0] OFF_INT_EN = 8'hb8;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SKIP_BIT = 31;
    localparam int BUSY_BIT = 31;
    localparam int RNW_BIT = 30;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 8;
    localparam int USED_LSB = 16;
    localparam int BYTES_LSB = 0;
    localparam int INT_SKIP_DONE = 0;
    localparam int INT_IND_DONE = 1;
    localparam int INT_HALFWAY = 23;
    localparam logic [31:0] INT_MASK = 32'h0080_0003;
    // ------------------------------------------------------------
    // Reset and threshold values
    // ------------------------------------------------------------
    localparam logic [15:0] TX_FREE_RST = 16'h1200;
    localparam logic [31:0] DROP_HALF_FROM = 32'h7fff_ffff;
    // ------------------------------------------------------------
    // Indirect access states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HMF_IDLE = 2'b00,
        HMF_WAIT = 2'b01
    } hmf_state_t;
endpackage

// >>> host_mac_fifo_status_csr_access_test.sv
`timescale 1ns/1ps
`default_nettype none
module host_mac_fifo_status_csr_access_test;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, skip, sdone, fdisc;
    logic req, rnw, ack, rerr;
    logic [3:0] pstrb;
    logic [7:0] paddr, caddr, rxs, txs;
    logic [15:0] rxd, txf;
    logic [31:0] pwdata, prdata, cwd, crd, rdat;
    int miscompares, n_tests;
    hmf_csr i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .irq, .rx_skip_to_next_frame(skip), .rx_skip_done(sdone),
        .rx_status_words_used(rxs), .rx_data_bytes_used(rxd), .tx_status_words_used(txs),
        .tx_data_bytes_free(txf), .frame_discarded(fdisc), .mac_csr_req(req),
        .mac_csr_rnw(rnw), .mac_csr_addr(caddr), .mac_csr_wdata(cwd), .mac_csr_ack(ack),
        .mac_csr_rdata(crd));
    hmf_far_model i_mac (.pclk, .presetn, .skip_req(skip), .skip_done(sdone), .csr_req(req),
        .csr_rnw(rnw), .csr_addr(caddr), .csr_wdata(cwd), .csr_ack(ack), .csr_rdata(crd));
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Bounded wait on a self-clearing bit 31
    task automatic poll(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        for (int i = 0; i < 40 && rdat[31] !== 1'b0; i++) begin
            apb(1'b0, a, 32'h0);
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #80000;
        miscompares++;
        results();
    end
    initial begin
        logic [7:0] ra [7];
        logic [31:0] re [7];
        ra = '{8'h78, 8'h7c, 8'h80, 8'ha0, 8'ha4, 8'ha8, 8'hb8};
        re = '{32'h0, 32'h0, 32'h1200, 32'h0, 32'h0, 32'h0, 32'h0};
        {presetn, psel, penable, pwrite, fdisc, paddr, pwdata} = '0;
        {rxs, rxd, txs, txf, rdat, pstrb} = {32'h0, 16'h1200, 32'h0, 4'hf};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rd_chk(ra[i], re[i]);
        $display("test reset values done");
        rxs <= 8'h12;
        rxd <= 16'h0344;
        txs <= 8'h05;
        txf <= 16'h0ffc;
        apb(1'b1, 8'h7c, 32'hffffffff);
        rd_chk(8'h7c, 32'h00120344);
        rd_chk(8'h80, 32'h00050ffc);
        $display("test fifo levels done");
        apb(1'b1, 8'hb8, hmf_pkg::INT_MASK);
        pstrb <= 4'h7;
        apb(1'b1, 8'h78, 32'h80000000);
        pstrb <= 4'hf;
        rd_chk(8'h78, 32'h0);
        apb(1'b1, 8'h78, 32'h80000000);
        rd_chk(8'h78, 32'h80000000);
        apb(1'b1, 8'h78, 32'h0);
        rd_chk(8'h78, 32'h80000000);
        poll(8'h78);
        chk(rdat, 32'h0);
        rd_chk(8'hb0, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'hb4, 32'h1);
        apb(1'b1, 8'hb8, 32'h0);
        apb(1'b1, 8'h78, 32'h80000000);
        poll(8'h78);
        rd_chk(8'hb0, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'hb4, 32'h1);
        rd_chk(8'hb0, 32'h0);
        $display("test skip done");
        repeat (3) begin
            @(posedge pclk);
            fdisc <= 1'b1;
            @(posedge pclk);
            fdisc <= 1'b0;
        end
        rd_chk(8'ha0, 32'h3);
        rd_chk(8'ha0, 32'h0);
        $display("test discard counter done");
        apb(1'b1, 8'ha8, 32'hcafe0001);
        apb(1'b1, 8'ha4, 32'h80000023);
        rd_chk(8'ha4, 32'h80000023);
        poll(8'ha4);
        chk(i_mac.mem[8'h23], 32'hcafe0001);
        apb(1'b1, 8'ha8, 32'h0);
        rd_chk(8'ha8, 32'h0);
        apb(1'b1, 8'ha4, 32'hc0000023);
        poll(8'ha4);
        rd_chk(8'ha8, 32'hcafe0001);
        apb(1'b1, 8'ha4, 32'hc0000007);
        poll(8'ha4);
        rd_chk(8'ha8, 32'ha5a5a507);
        apb(1'b0, 8'h90, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test indirect access done");
        results();
    end
endmodule
`default_nettype wire
